/* File: logic/isr_pkg.sv */
// Constants shared by the I2C slave-receive block
package isr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 4;
  localparam int SADR_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_BUS_CTRL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BUS_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BUS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDR   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_IF_ENABLE  = 0;
  localparam int BIT_MASTER_SEL = 1;
  localparam int BIT_XMIT_SEL   = 2;
  localparam int POS_XFER_CLK   = 4;
  localparam int XFER_CLK_W     = 4;
  localparam int BIT_ORDER      = 0;
  localparam int BIT_WAIT       = 1;
  localparam int BIT_ACK_VALUE  = 0;
  localparam int BIT_RX_FULL    = 0;
  localparam int BIT_BUSY       = 1;
  localparam int BIT_STRETCH    = 2;
  localparam int EVT_W          = 3;
  localparam int EVT_MATCH      = 0;
  localparam int EVT_BYTE       = 1;
  localparam int EVT_STOP       = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and frame counts
  localparam logic [DATA_W-1:0] RST_BUS_CTRL_A = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_BUS_MODE   = 32'h00000000;
  localparam logic              RST_ACK_VALUE  = 1'h0;
  localparam logic [SADR_W-1:0] RST_OWN_ADDR   = 7'h00;
  localparam logic [EVT_W-1:0]  RST_EVT        = 3'h0;
  localparam logic              RST_LINE_SYNC  = 1'h1;
  localparam logic [CNT_W-1:0]  CNT_DATA_BITS  = 4'h8;
  localparam logic [CNT_W-1:0]  CNT_ACK_BIT    = 4'h9;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_SKIP
  } isr_state_type;

endpackage

/* File: logic/isr_sync2.sv */
// Two-flop synchroniser for one bus line
`timescale 1ns/10ps
module isr_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      q_out
);
  import isr_pkg::*;

  logic meta_reg;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= RST_LINE_SYNC;
      q_out    <= RST_LINE_SYNC;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule // isr_sync2

/* File: logic/isr_shifter.sv */
// Receive shift register with selectable bit order
`timescale 1ns/10ps
module isr_shifter (
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      clear_in,
  input  wire logic                      shift_in,
  input  wire logic                      lsb_first_in,
  input  wire logic                      bit_in,
  output logic [isr_pkg::BYTE_W-1:0]     byte_out
);
  import isr_pkg::*;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byte_out <= '0;
    end else if (clear_in) begin
      byte_out <= '0;
    end else if (shift_in) begin
      if (lsb_first_in) begin
        byte_out <= {bit_in, byte_out[BYTE_W-1:1]};
      end else begin
        byte_out <= {byte_out[BYTE_W-2:0], bit_in};
      end
    end
  end

endmodule // isr_shifter

/* File: logic/isr_slave_rx.sv */
// I2C slave-receive path with APB register access
//
// Function
// - Slave receive mode waits for address match
// - Compare address on first frame after start
// - Drive acknowledge level at ninth rising edge
// - Match sets full flag; data read clears
// - Address byte with direction bit is readable
// - Full at eighth falling edge stretches SCL
// - Acknowledge change applies to next frame
// - Last byte obtained by a plain read
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
module isr_slave_rx (
  input  wire logic                      REF_CLK_IN,
  input  wire logic                      RST_B_IN,
  input  wire logic                      PSEL_IN,
  input  wire logic                      PENABLE_IN,
  input  wire logic                      PWRITE_IN,
  input  wire logic [isr_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [isr_pkg::DATA_W-1:0] PWDATA_IN,
  output logic [isr_pkg::DATA_W-1:0]     PRDATA_OUT,
  output logic                           PREADY_OUT,
  output logic                           PSLVERR_OUT,
  input  wire logic                      SCL_IN,
  output logic                           SCL_OUT,
  output logic                           SCL_OE_OUT,
  input  wire logic                      SDA_IN,
  output logic                           SDA_OUT,
  output logic                           SDA_OE_OUT,
  output logic                           IRQ_OUT
);
  import isr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [DATA_W-1:0]  bus_ctrl_a_reg;
  logic [DATA_W-1:0]  bus_mode_reg;
  logic               ack_value_bit;
  logic [SADR_W-1:0]  own_addr_reg;
  logic [EVT_W-1:0]   evt_status_reg;
  logic [EVT_W-1:0]   evt_mask_reg;
  logic [EVT_W-1:0]   evt_next;
  logic [BYTE_W-1:0]  rx_data_reg;
  logic               rx_full_flag;
  logic               ack_frame_reg;
  logic [CNT_W-1:0]   bit_cnt_reg;
  isr_state_type      state_reg;
  logic               scl_s;
  logic               sda_s;
  logic               scl_d_reg;
  logic               sda_d_reg;
  logic [BYTE_W-1:0]  shift_byte;
  logic               bus_if_enable;
  logic               bit_order_select;
  logic               master_select;
  logic               transmit_select;
  logic               slave_rx_mode;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;
  logic               addr_hit;
  logic               ninth_rise;
  logic               eighth_fall;
  logic               ninth_fall;
  logic               take_byte;
  logic               shift_en;
  logic               acc_setup;
  logic               acc_done;
  logic               wr_done;
  logic               rd_pulse;
  logic               addr_known;
  logic [DATA_W-1:0]  rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and edge finding
  isr_sync2 u_scl_sync (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (SCL_IN),
    .q_out    (scl_s)
  );

  isr_sync2 u_sda_sync (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (SDA_IN),
    .q_out    (sda_s)
  );

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      scl_d_reg <= RST_LINE_SYNC;
      sda_d_reg <= RST_LINE_SYNC;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Own ack pull falls while SCL is high; mask it from start/stop
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s & ~SDA_OE_OUT;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s & ~SDA_OE_OUT;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  assign bus_if_enable    = bus_ctrl_a_reg[BIT_IF_ENABLE];
  assign master_select    = bus_ctrl_a_reg[BIT_MASTER_SEL];
  assign transmit_select  = bus_ctrl_a_reg[BIT_XMIT_SEL];
  assign bit_order_select = bus_mode_reg[BIT_ORDER];
  // Setup is software's job; only this combination receives
  assign slave_rx_mode = bus_if_enable & ~master_select & ~transmit_select;

  assign ninth_rise  = scl_rise & (bit_cnt_reg == CNT_DATA_BITS);
  assign eighth_fall = scl_fall & (bit_cnt_reg == CNT_DATA_BITS);
  assign ninth_fall  = scl_fall & (bit_cnt_reg == CNT_ACK_BIT);
  assign addr_hit    = (shift_byte[BYTE_W-1:1] == own_addr_reg)
                     & ~shift_byte[0];
  assign take_byte   = ninth_rise & ((state_reg == ST_ADDR & addr_hit)
                     | (state_reg == ST_DATA));
  assign shift_en    = scl_rise & (bit_cnt_reg < CNT_DATA_BITS)
                     & (state_reg == ST_ADDR | state_reg == ST_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg <= ST_IDLE;
    end else if (!slave_rx_mode) begin
      state_reg <= ST_IDLE;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
    end else if (ninth_rise && state_reg == ST_ADDR) begin
      state_reg <= addr_hit ? ST_DATA : ST_SKIP;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bit_cnt_reg <= '0;
    end else if (!slave_rx_mode || start_det) begin
      bit_cnt_reg <= '0;
    end else if (ninth_fall) begin
      bit_cnt_reg <= '0;
    end else if (scl_rise && bit_cnt_reg < CNT_ACK_BIT) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Address frame always MSB first so the compare is order-free
  isr_shifter u_shifter (
    .clk_in       (REF_CLK_IN),
    .rst_b_in     (RST_B_IN),
    .clear_in     (start_det),
    .shift_in     (shift_en),
    .lsb_first_in (bit_order_select & (state_reg == ST_DATA)),
    .bit_in       (sda_s),
    .byte_out     (shift_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge and receive data
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ack_frame_reg <= RST_ACK_VALUE;
    end else if (start_det || ninth_fall) begin
      ack_frame_reg <= ack_value_bit;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SDA_OE_OUT <= 1'b0;
    end else if (!slave_rx_mode || start_det || stop_det) begin
      SDA_OE_OUT <= 1'b0;
    end else if (take_byte) begin
      SDA_OE_OUT <= ~ack_frame_reg;
    end else if (ninth_fall) begin
      SDA_OE_OUT <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_data_reg <= '0;
    end else if (take_byte) begin
      rx_data_reg <= shift_byte;
    end
  end

  // Set wins over the read that clears it
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_full_flag <= 1'b0;
    end else if (take_byte) begin
      rx_full_flag <= 1'b1;
    end else if (rd_pulse) begin
      rx_full_flag <= 1'b0;
    end
  end

  // Stretch ends on a read, a stop or leaving slave receive mode, so a slow CPU never loses a byte to the next data frame
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SCL_OE_OUT <= 1'b0;
    end else if (!slave_rx_mode || stop_det) begin
      SCL_OE_OUT <= 1'b0;
    end else if (eighth_fall && state_reg == ST_DATA && rx_full_flag
                 && !rd_pulse) begin
      SCL_OE_OUT <= 1'b1;
    end else if (rd_pulse) begin
      SCL_OE_OUT <= 1'b0;
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end else begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  assign acc_setup = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  assign acc_done  = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_done   = acc_done & PWRITE_IN & addr_known;
  assign rd_pulse  = acc_done & ~PWRITE_IN & (PADDR_IN == OFS_RX_DATA);

  always_comb begin
    addr_known = 1'b1;
    rd_mux     = '0;
    unique case (PADDR_IN)
      OFS_BUS_CTRL_A: rd_mux = bus_ctrl_a_reg;
      OFS_BUS_MODE:   rd_mux = bus_mode_reg;
      OFS_IRQ_ENABLE: rd_mux[BIT_ACK_VALUE] = ack_value_bit;
      OFS_BUS_STATUS: begin
        rd_mux[BIT_RX_FULL] = rx_full_flag;
        rd_mux[BIT_BUSY]    = (state_reg != ST_IDLE);
        rd_mux[BIT_STRETCH] = SCL_OE_OUT;
      end
      OFS_RX_DATA:    rd_mux[BYTE_W-1:0] = rx_data_reg;
      OFS_OWN_ADDR:   rd_mux[SADR_W-1:0] = own_addr_reg;
      OFS_EVT_STATUS: rd_mux[EVT_W-1:0] = evt_status_reg;
      OFS_EVT_MASK:   rd_mux[EVT_W-1:0] = evt_mask_reg;
      default:        addr_known = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= '0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= acc_setup;
      PSLVERR_OUT <= acc_setup & ~addr_known;
      PRDATA_OUT  <= (acc_setup && !PWRITE_IN) ? rd_mux : '0;
    end
  end

  // Enable, select, order, acknowledge value, address and event mask steer logic; rest is stored
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bus_ctrl_a_reg <= RST_BUS_CTRL_A;
      bus_mode_reg   <= RST_BUS_MODE;
      ack_value_bit  <= RST_ACK_VALUE;
      own_addr_reg   <= RST_OWN_ADDR;
      evt_mask_reg   <= RST_EVT;
    end else if (wr_done) begin
      unique case (PADDR_IN)
        OFS_BUS_CTRL_A: bus_ctrl_a_reg <= {23'h000000, PWDATA_IN[8:0]};
        OFS_BUS_MODE:   bus_mode_reg   <= {30'h00000000, PWDATA_IN[1:0]};
        OFS_IRQ_ENABLE: ack_value_bit  <= PWDATA_IN[BIT_ACK_VALUE];
        OFS_OWN_ADDR:   own_addr_reg   <= PWDATA_IN[SADR_W-1:0];
        OFS_EVT_MASK:   evt_mask_reg   <= PWDATA_IN[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  always_comb begin
    evt_next            = '0;
    evt_next[EVT_MATCH] = take_byte & (state_reg == ST_ADDR);
    evt_next[EVT_BYTE]  = take_byte & (state_reg == ST_DATA);
    evt_next[EVT_STOP]  = stop_det & (state_reg != ST_IDLE);
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      evt_status_reg <= RST_EVT;
    end else if (wr_done && PADDR_IN == OFS_EVT_STATUS) begin
      evt_status_reg <= (evt_status_reg & ~PWDATA_IN[EVT_W-1:0]) | evt_next;
    end else begin
      evt_status_reg <= evt_status_reg | evt_next;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(evt_status_reg & evt_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  sequence s_addr_hit;
    state_reg == ST_ADDR && ninth_rise && addr_hit && slave_rx_mode
      && !start_det && !stop_det;
  endsequence

  sequence s_full_at_eighth;
    state_reg == ST_DATA && eighth_fall && rx_full_flag && !rd_pulse
      && slave_rx_mode && !stop_det;
  endsequence

  a_quiet_until_match: assert property (
    (state_reg == ST_IDLE || state_reg == ST_SKIP)
      |-> !SDA_OE_OUT && !SCL_OE_OUT && !take_byte)
    else $error("Line driven without address match");

  a_start_to_addr: assert property (
    (start_det && slave_rx_mode)
      |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
    else $error("Start did not open an address frame");

  a_ack_on_ninth: assert property (
    s_addr_hit |=> SDA_OE_OUT == !$past(ack_frame_reg)
      && state_reg == ST_DATA)
    else $error("Acknowledge level wrong at ninth clock");

  a_match_sets_full: assert property (
    s_addr_hit |=> rx_full_flag ##1 (rx_full_flag || $past(rd_pulse)))
    else $error("Address match did not set full flag");

  a_read_clears_full: assert property (
    (rd_pulse && !take_byte) |=> !rx_full_flag)
    else $error("Data read did not clear full flag");

  a_addr_byte_shown: assert property (
    s_addr_hit |=> rx_data_reg == $past(shift_byte)
      && rx_data_reg[0] == 1'b0)
    else $error("Address byte not presented");

  a_stretch_start: assert property (
    s_full_at_eighth |=> SCL_OE_OUT)
    else $error("Stretch not applied at eighth falling edge");

  a_stretch_holds: assert property (
    (SCL_OE_OUT && !rd_pulse && !stop_det && slave_rx_mode)
      |=> SCL_OE_OUT)
    else $error("Stretch released without a read");

  a_ack_next_frame: assert property (
    (!start_det && !ninth_fall) |=> $stable(ack_frame_reg))
    else $error("Acknowledge level changed inside a frame");

  a_read_releases: assert property (
    (SCL_OE_OUT && rd_pulse) |=> !SCL_OE_OUT ##1 !rx_full_flag
      || take_byte)
    else $error("Read did not release the clock line");

  a_sample_msb: assert property (
    (shift_en && !start_det && !(bit_order_select
      && state_reg == ST_DATA)) |=> shift_byte[0] == $past(sda_s))
    else $error("MSB-first sample wrong");

  a_sample_lsb: assert property (
    (shift_en && !start_det && bit_order_select
      && state_reg == ST_DATA) |=> shift_byte[BYTE_W-1] == $past(sda_s))
    else $error("LSB-first sample wrong");

  a_irq_follows: assert property (
    (|(evt_status_reg & evt_mask_reg)) |=> IRQ_OUT)
    else $error("Interrupt not raised");

endmodule // isr_slave_rx

/* File: tb/isr_i2c_master_model.sv */
// Behavioural I2C bus master that drives the slave-receive block
`timescale 1ns/10ps
module isr_i2c_master_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_low_out,
  output logic      sda_low_out
);
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bounded wait: a stretching slave may hold the clock low
  task automatic wait_high();
    int n;
    n = 0;
    while (scl_in !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
  endtask
  // Works from idle and as a repeated start
  task automatic start_cond();
    // Off the clock edge so the synchronisers never race the pins
    #3;
    sda_low_out = 1'b0;
    #40;
    scl_low_out = 1'b0;
    wait_high();
    #40;
    sda_low_out = 1'b1;
    #80;
    scl_low_out = 1'b1;
    #40;
  endtask
  // Eight data pulses, then a released ninth pulse for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    #3;
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      #40;
      scl_low_out = 1'b0;
      wait_high();
      #80;
      scl_low_out = 1'b1;
      #40;
    end
    sda_low_out = 1'b0;
    #40;
    scl_low_out = 1'b0;
    wait_high();
    #40;
    ack = sda_in;
    #40;
    scl_low_out = 1'b1;
    #40;
  endtask
  task automatic stop_cond();
    #3;
    sda_low_out = 1'b1;
    #40;
    scl_low_out = 1'b0;
    wait_high();
    #80;
    sda_low_out = 1'b0;
    #80;
  endtask
endmodule // isr_i2c_master_model

/* File: tb/isr_slave_rx_tb_top.sv */
// Self-checking bench for the I2C slave-receive block
`timescale 1ns/10ps
module isr_slave_rx_tb_top;
  import isr_pkg::*;
  logic        ref_clk, rst_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, scl_oe, sda_oe, irq, m_scl_low, m_sda_low;
  logic        scl_w, sda_w, ack, scl_o, sda_o;
  logic [6:0]  own;
  logic [7:0]  d1, d2, d3;
  logic [32:0] exp_q[$];
  int          err_total, tests_run, cyc;
  assign scl_w = ~m_scl_low & (scl_oe ? scl_o : 1'b1);
  assign sda_w = ~m_sda_low & (sda_oe ? sda_o : 1'b1);
  isr_slave_rx dut_u (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCL_IN(scl_w),
    .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .IRQ_OUT(irq));
  isr_i2c_master_model m_u (.scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(m_scl_low), .sda_low_out(m_sda_low));
  ////////////////////////////////////////////////////////////////////////////
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the fewer than two thousand cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  // Result watcher: every completed transfer consumes the oldest note
  always @(posedge ref_clk) begin
    if (pready === 1'b1 && psel && penable)
      check({pslverr, pwrite ? 32'h00000000 : prdata}, exp_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    int n;
    exp_q.push_back(exp);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 100)
      err_total++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask
  task automatic wait_stretch();
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 1000) begin
      n++;
      @(posedge ref_clk);
    end
    check(scl_oe, 1'b1);
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7-i];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000;
    err_total = 0; tests_run = 0; cyc = 0;
    void'($urandom(89));
    own = 7'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    d3 = 8'($urandom);
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b0, OFS_BUS_CTRL_A, 32'h0, {1'b0, RST_BUS_CTRL_A});
    apb(1'b0, OFS_OWN_ADDR, 32'h0, 33'h000000000);
    apb(1'b0, 8'h20, 32'h0, 33'h100000000);
    apb(1'b1, 8'h24, 32'h5, 33'h100000000);
    $display("test registers done");
    wr(OFS_OWN_ADDR, {25'h0, own});
    wr(OFS_BUS_MODE, 32'h0);
    wr(OFS_EVT_MASK, 32'h7);
    wr(OFS_BUS_CTRL_A, 32'h1);
    m_u.start_cond();
    m_u.send_byte({own, 1'b0}, ack);
    check(ack, 1'b0);
    apb(1'b0, OFS_BUS_STATUS, 32'h0, 33'h000000003);
    check(irq, 1'b1);
    wr(OFS_IRQ_ENABLE, 32'h1);
    fork
      m_u.send_byte(d1, ack);
      begin
        wait_stretch();
        apb(1'b0, OFS_BUS_STATUS, 32'h0, 33'h000000007);
        apb(1'b0, OFS_RX_DATA, 32'h0, {25'h0, own, 1'b0});
      end
    join
    check(ack, 1'b0);
    fork
      m_u.send_byte(d2, ack);
      begin
        wait_stretch();
        apb(1'b0, OFS_RX_DATA, 32'h0, {25'h0, d1});
      end
    join
    check(ack, 1'b1);
    apb(1'b0, OFS_RX_DATA, 32'h0, {25'h0, d2});
    m_u.stop_cond();
    apb(1'b0, OFS_BUS_STATUS, 32'h0, 33'h000000000);
    apb(1'b0, OFS_EVT_STATUS, 32'h0, 33'h000000007);
    wr(OFS_EVT_STATUS, 32'h7);
    apb(1'b0, OFS_EVT_STATUS, 32'h0, 33'h000000000);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b0);
    $display("test msb first done");
    wr(OFS_IRQ_ENABLE, 32'h0);
    wr(OFS_BUS_MODE, 32'h1);
    wr(OFS_EVT_MASK, 32'h0);
    wr(OFS_BUS_CTRL_A, 32'h3);
    m_u.start_cond();
    m_u.send_byte({own, 1'b0}, ack);
    check(ack, 1'b1);
    wr(OFS_BUS_CTRL_A, 32'h1);
    m_u.start_cond();
    m_u.send_byte({own ^ 7'h01, 1'b0}, ack);
    check(ack, 1'b1);
    apb(1'b0, OFS_EVT_STATUS, 32'h0, 33'h000000000);
    m_u.start_cond();
    m_u.send_byte({own, 1'b0}, ack);
    check(ack, 1'b0);
    apb(1'b0, OFS_RX_DATA, 32'h0, {25'h0, own, 1'b0});
    m_u.send_byte(d3, ack);
    check(ack, 1'b0);
    apb(1'b0, OFS_RX_DATA, 32'h0, {25'h0, rev8(d3)});
    m_u.stop_cond();
    apb(1'b0, OFS_EVT_STATUS, 32'h0, 33'h000000007);
    check(irq, 1'b0);
    wr(OFS_EVT_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b1);
    $display("test lsb first done");
    final_report();
  end
endmodule // isr_slave_rx_tb_top
